// File: rtl/gpp_pkg.sv
/*
 * gpp_pkg: register offsets, field layout, reset values and carrier types
 * for the eight-pin port.
 * Assumes a 16-bit register port addressed by byte offsets.
 */
package gpp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned GPP_PINS   = 8;
  localparam int unsigned GPP_DATA_W = 16;
  localparam int unsigned GPP_ADDR_W = 12;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] GPP_OFF_DRIVE_EN   = 12'h004;
  localparam logic [11:0] GPP_OFF_PULL_EN    = 12'h008;
  localparam logic [11:0] GPP_OFF_INPUT_EN   = 12'h00C;
  localparam logic [11:0] GPP_OFF_INPUT_SMP  = 12'h010;
  localparam logic [11:0] GPP_OFF_OUT_DATA   = 12'h014;
  localparam logic [11:0] GPP_OFF_OUT_SET    = 12'h018;
  localparam logic [11:0] GPP_OFF_OUT_CLEAR  = 12'h01C;
  localparam logic [11:0] GPP_OFF_OUT_TOGGLE = 12'h020;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GPP_FIELD_LSB = 0;
  localparam logic [7:0]  GPP_RST_FIELD = 8'h00;
  localparam logic [15:0] GPP_RST_WORD  = 16'h0000;
  localparam logic [7:0]  GPP_RSVD_HI   = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } gpp_req_t;

  typedef struct packed {
    logic [7:0] out_o;
    logic [7:0] oe_n;
    logic [7:0] pull;
    logic [7:0] in_en;
  } gpp_pad_t;

endpackage : gpp_pkg

// File: rtl/gpp_out_bit.sv
/*
 * gpp_out_bit: next value of one output data bit from direct, set,
 * clear and toggle writes.
 * Assumes at most one write strobe is high in a cycle.
 */
module gpp_out_bit
  import gpp_pkg::*;
(
  input  wire logic cur,
  input  wire logic wr_data,
  input  wire logic wr_set,
  input  wire logic wr_clr,
  input  wire logic wr_tgl,
  input  wire logic wbit,
  output logic      nxt
);

  // ----------------------------------------------------------------
  // update
  // ----------------------------------------------------------------
  always_comb begin
    nxt = cur;
    if (wr_data) begin
      nxt = wbit;
    end else if (wr_set && wbit) begin
      nxt = 1'b1;
    end else if (wr_clr && wbit) begin
      nxt = 1'b0;
    end else if (wr_tgl && wbit) begin
      nxt = ~cur;
    end
  end

endmodule : gpp_out_bit

// File: rtl/gpp_in_bit.sv
/*
 * gpp_in_bit: registered sample of one pin, gated by its input path.
 * Assumes pin levels are synchronous to sys_clk.
 */
module gpp_in_bit
  import gpp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic pin,
  input  wire logic in_en,
  output logic      smp_q
);

  // ----------------------------------------------------------------
  // sample
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      smp_q <= 1'b0;
    end else begin
      smp_q <= pin & in_en;
    end
  end

endmodule : gpp_in_bit

// File: rtl/gpp_port.sv
/*
 * gpp_port: eight-pin general-purpose port with pull, input path, drive
 * enable and output data registers plus set, clear and toggle writes.
 * Assumes a one-cycle strobe register port, read data one cycle later,
 * pins synchronous to sys_clk, pads resolved outside.
 */
// The plain strobed port was decided locally.
// Overview of operation
// - each pull enable bit turns its pin's pull resistor on or off.
// - each input path bit connects or disconnects its pin's input.
// - input sample register returns the registered pin level when enabled.
// - a disabled input path reads as zero whatever the pin.
// - output data bit one drives pin high, zero drives low.
// - set register ones force outputs high, zeros leave them.
// - clear register ones force outputs low, zeros leave them.
// - toggle register ones invert outputs, zeros leave them.
// - all registers reset to zero; upper eight bits read zero.
// - pin is driven only while its drive enable bit is one.
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned PINS = GPP_PINS
)(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic [GPP_ADDR_W-1:0] reg_addr,
  input  wire logic [GPP_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [GPP_DATA_W-1:0] reg_rdata,
  input  wire logic [PINS-1:0]       port_pin_in,
  output logic      [PINS-1:0]       port_pin_out,
  output logic      [PINS-1:0]       port_pin_oe_n,
  output logic      [PINS-1:0]       pull_enable_bits,
  output logic      [PINS-1:0]       input_path_bits
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (PINS != GPP_PINS) begin : g_bad_pins
    $error("gpp_port serves exactly eight pins");
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  gpp_req_t   req;
  logic       wr_drive;
  logic       wr_pull;
  logic       wr_inen;
  logic       wr_data;
  logic       wr_set;
  logic       wr_clr;
  logic       wr_tgl;

  assign req      = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign wr_drive = req.wr && (req.addr == GPP_OFF_DRIVE_EN);
  assign wr_pull  = req.wr && (req.addr == GPP_OFF_PULL_EN);
  assign wr_inen  = req.wr && (req.addr == GPP_OFF_INPUT_EN);
  assign wr_data  = req.wr && (req.addr == GPP_OFF_OUT_DATA);
  assign wr_set   = req.wr && (req.addr == GPP_OFF_OUT_SET);
  assign wr_clr   = req.wr && (req.addr == GPP_OFF_OUT_CLEAR);
  assign wr_tgl   = req.wr && (req.addr == GPP_OFF_OUT_TOGGLE);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] drive_enable_bits_q;
  logic [7:0] pull_enable_bits_q;
  logic [7:0] input_path_bits_q;
  logic [7:0] out_data_q;
  logic [7:0] out_data_d;
  logic [7:0] smp_q;
  gpp_pad_t   pad;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      drive_enable_bits_q <= GPP_RST_FIELD;
    end else if (wr_drive) begin
      drive_enable_bits_q <= req.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pull_enable_bits_q <= GPP_RST_FIELD;
    end else if (wr_pull) begin
      pull_enable_bits_q <= req.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      input_path_bits_q <= GPP_RST_FIELD;
    end else if (wr_inen) begin
      input_path_bits_q <= req.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_data_q <= GPP_RST_FIELD;
    end else begin
      out_data_q <= out_data_d;
    end
  end

  // ----------------------------------------------------------------
  // per-pin logic
  // ----------------------------------------------------------------
  for (genvar i = 0; i < GPP_PINS; i++) begin : g_pin
    gpp_out_bit u_out (
      .cur     (out_data_q[i]),
      .wr_data (wr_data),
      .wr_set  (wr_set),
      .wr_clr  (wr_clr),
      .wr_tgl  (wr_tgl),
      .wbit    (req.wdata[i]),
      .nxt     (out_data_d[i])
    );
    gpp_in_bit u_in (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .pin     (port_pin_in[i]),
      .in_en   (input_path_bits_q[i]),
      .smp_q   (smp_q[i])
    );
  end

  // ----------------------------------------------------------------
  // pad outputs
  // ----------------------------------------------------------------
  always_comb begin
    pad.out_o = out_data_d;
    pad.oe_n  = ~(wr_drive ? req.wdata[7:0] : drive_enable_bits_q);
    pad.pull  = wr_pull ? req.wdata[7:0] : pull_enable_bits_q;
    pad.in_en = wr_inen ? req.wdata[7:0] : input_path_bits_q;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_pin_out     <= GPP_RST_FIELD;
      port_pin_oe_n    <= ~GPP_RST_FIELD;
      pull_enable_bits <= GPP_RST_FIELD;
      input_path_bits  <= GPP_RST_FIELD;
    end else begin
      port_pin_out     <= pad.out_o;
      port_pin_oe_n    <= pad.oe_n;
      pull_enable_bits <= pad.pull;
      input_path_bits  <= pad.in_en;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rd_field;

  always_comb begin
    rd_field = GPP_RST_FIELD;
    unique case (req.addr)
      GPP_OFF_DRIVE_EN:   rd_field = drive_enable_bits_q;
      GPP_OFF_PULL_EN:    rd_field = pull_enable_bits_q;
      GPP_OFF_INPUT_EN:   rd_field = input_path_bits_q;
      GPP_OFF_INPUT_SMP:  rd_field = smp_q;
      GPP_OFF_OUT_DATA:   rd_field = out_data_q;
      GPP_OFF_OUT_SET:    rd_field = GPP_RST_FIELD;
      GPP_OFF_OUT_CLEAR:  rd_field = GPP_RST_FIELD;
      GPP_OFF_OUT_TOGGLE: rd_field = GPP_RST_FIELD;
      default:            rd_field = GPP_RST_FIELD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= GPP_RST_WORD;
    end else if (req.rd) begin
      reg_rdata <= {GPP_RSVD_HI, rd_field};
    end else begin
      reg_rdata <= GPP_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pull_follow;
    @(posedge sys_clk) disable iff (!resetn)
      wr_pull |=> (pull_enable_bits == $past(reg_wdata[7:0]));
  endproperty
  a_pull_follow: assert property (p_pull_follow) else $error("pull bits not applied");

  property p_inen_follow;
    @(posedge sys_clk) disable iff (!resetn)
      wr_inen |=> (input_path_bits == $past(reg_wdata[7:0]));
  endproperty
  a_inen_follow: assert property (p_inen_follow) else $error("input path bits not applied");

  property p_smp_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == GPP_OFF_INPUT_SMP) |=> (reg_rdata[7:0] == $past(smp_q));
  endproperty
  a_smp_read: assert property (p_smp_read) else $error("sample read wrong");

  property p_smp_gated;
    @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> ((smp_q & ~$past(input_path_bits_q)) == 8'h00);
  endproperty
  a_smp_gated: assert property (p_smp_gated) else $error("disabled input not zero");

  property p_data_write;
    @(posedge sys_clk) disable iff (!resetn)
      wr_data |=> (port_pin_out == $past(reg_wdata[7:0]));
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write not on pins");

  property p_set;
    @(posedge sys_clk) disable iff (!resetn)
      wr_set |=> (out_data_q == ($past(out_data_q) | $past(reg_wdata[7:0])));
  endproperty
  a_set: assert property (p_set) else $error("set write wrong");

  property p_clr;
    @(posedge sys_clk) disable iff (!resetn)
      wr_clr |=> (out_data_q == ($past(out_data_q) & ~$past(reg_wdata[7:0])));
  endproperty
  a_clr: assert property (p_clr) else $error("clear write wrong");

  property p_tgl;
    @(posedge sys_clk) disable iff (!resetn)
      wr_tgl |=> (port_pin_out == ($past(out_data_q) ^ $past(reg_wdata[7:0])));
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle write wrong");

  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (!resetn)
      reg_rdata[15:8] == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_drive;
    @(posedge sys_clk) disable iff (!resetn)
      wr_drive |=> (port_pin_oe_n == ~$past(reg_wdata[7:0]));
  endproperty
  a_drive: assert property (p_drive) else $error("drive enable wrong");

  property p_out_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == GPP_OFF_OUT_DATA) |=> (reg_rdata[7:0] == $past(out_data_q));
  endproperty
  a_out_read: assert property (p_out_read) else $error("output data read wrong");

  property p_wo_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && (reg_addr == GPP_OFF_OUT_SET || reg_addr == GPP_OFF_OUT_CLEAR ||
                  reg_addr == GPP_OFF_OUT_TOGGLE)) |=> (reg_rdata == 16'h0000);
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only reg not zero");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (!resetn)
      !reg_rd |=> (reg_rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

  property p_drive_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == GPP_OFF_DRIVE_EN) |=> (reg_rdata[7:0] == $past(drive_enable_bits_q));
  endproperty
  a_drive_read: assert property (p_drive_read) else $error("drive enable read wrong");

  property p_pull_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == GPP_OFF_PULL_EN) |=> (reg_rdata[7:0] == $past(pull_enable_bits_q));
  endproperty
  a_pull_read: assert property (p_pull_read) else $error("pull enable read wrong");

  property p_inen_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == GPP_OFF_INPUT_EN) |=> (reg_rdata[7:0] == $past(input_path_bits_q));
  endproperty
  a_inen_read: assert property (p_inen_read) else $error("input path read wrong");

  property p_smp_level;
    @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> (smp_q == ($past(port_pin_in) & $past(input_path_bits_q)));
  endproperty
  a_smp_level: assert property (p_smp_level) else $error("pin sample wrong");

  property p_out_hold;
    @(posedge sys_clk) disable iff (!resetn)
      !(wr_data || wr_set || wr_clr || wr_tgl) |=> $stable(port_pin_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved without write");

  property p_pins_match;
    @(posedge sys_clk) disable iff (!resetn)
      port_pin_out == out_data_q;
  endproperty
  a_pins_match: assert property (p_pins_match) else $error("pins differ from output data");

  property p_oe_match;
    @(posedge sys_clk) disable iff (!resetn)
      port_pin_oe_n == ~drive_enable_bits_q;
  endproperty
  a_oe_match: assert property (p_oe_match) else $error("drive enable pins differ");

  property p_pull_match;
    @(posedge sys_clk) disable iff (!resetn)
      (pull_enable_bits == pull_enable_bits_q) && (input_path_bits == input_path_bits_q);
  endproperty
  a_pull_match: assert property (p_pull_match) else $error("pull or path pins differ");

endmodule : gpp_port

// File: sim/gpp_board.sv
/*
 * gpp_board: board-side model of the eight port pins.
 * Assumes the bench sets which pins the board drives; pulls go high.
 */
module gpp_board #(
  parameter logic PULL_LVL = 1'b1
)(
  input  wire logic       sys_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pull,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  logic [7:0] float_q = 8'hA5;

  // undriven, unpulled pins wander every cycle
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pull[i]) begin
        pin_lvl[i] = PULL_LVL;
      end else begin
        pin_lvl[i] = float_q[i];
      end
    end
  end
endmodule : gpp_board

// File: sim/gpp_port_tb.sv
/*
 * gpp_port_tb: random and directed register traffic against an integer
 * model, checked at every falling edge.
 * Assumes the gpp_board pin model and one 200 MHz clock.
 */
module gpp_port_tb
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk;
  logic        resetn;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [7:0]  pin_lvl;
  logic [7:0]  pin_out;
  logic [7:0]  oe_n;
  logic [7:0]  pull_bits;
  logic [7:0]  path_bits;
  logic [7:0]  ext_en;
  logic [7:0]  ext_val;
  logic        rd_pend;
  int          errors;
  int          checked;
  int          m_oen, m_pe, m_ien, m_smp, m_od, m_exp;
  logic [11:0] addrs [11] = '{12'h000, GPP_OFF_DRIVE_EN, GPP_OFF_PULL_EN, GPP_OFF_INPUT_EN,
                              GPP_OFF_INPUT_SMP, GPP_OFF_OUT_DATA, GPP_OFF_OUT_SET,
                              GPP_OFF_OUT_CLEAR, GPP_OFF_OUT_TOGGLE, 12'h024, 12'hFFC};

  gpp_port #(.PINS(8)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_pin_in(pin_lvl),
    .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .pull_enable_bits(pull_bits),
    .input_path_bits(path_bits)
  );

  gpp_board u_board (
    .sys_clk(sys_clk), .pin_out(pin_out), .oe_n(oe_n), .pull(pull_bits),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : bus

  task automatic sweep(input string name);
    foreach (addrs[i]) bus(1'b0, 1'b1, addrs[i], 16'h0000);
    bus(1'b0, 1'b0, 12'h000, 16'h0000);
    @(posedge sys_clk);
    $display("test %s done", name);
  endtask : sweep

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // reference model and checks
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {m_oen, m_pe, m_ien, m_smp, m_od, m_exp} <= '0;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= reg_rd;
      m_smp   <= int'(pin_lvl) & m_ien;
      if (reg_rd) begin
        case (reg_addr)
          GPP_OFF_DRIVE_EN:  m_exp <= m_oen;
          GPP_OFF_PULL_EN:   m_exp <= m_pe;
          GPP_OFF_INPUT_EN:  m_exp <= m_ien;
          GPP_OFF_INPUT_SMP: m_exp <= m_smp;
          GPP_OFF_OUT_DATA:  m_exp <= m_od;
          default:           m_exp <= 0;
        endcase
      end
      if (reg_wr) begin
        case (reg_addr)
          GPP_OFF_DRIVE_EN:   m_oen <= int'(reg_wdata[7:0]);
          GPP_OFF_PULL_EN:    m_pe  <= int'(reg_wdata[7:0]);
          GPP_OFF_INPUT_EN:   m_ien <= int'(reg_wdata[7:0]);
          GPP_OFF_OUT_DATA:   m_od  <= int'(reg_wdata[7:0]);
          GPP_OFF_OUT_SET:    m_od  <= m_od | int'(reg_wdata[7:0]);
          GPP_OFF_OUT_CLEAR:  m_od  <= m_od & ~int'(reg_wdata[7:0]);
          GPP_OFF_OUT_TOGGLE: m_od  <= m_od ^ int'(reg_wdata[7:0]);
          default: ;
        endcase
      end
    end
  end

  always @(negedge sys_clk) begin
    chk(reg_rdata, rd_pend ? 16'(m_exp) : 16'h0000, "rdata");
    chk({8'h00, pin_out}, 16'(m_od), "pin_out");
    chk({8'h00, oe_n}, {8'h00, ~8'(m_oen)}, "oe_n");
    chk({8'h00, pull_bits}, 16'(m_pe), "pull");
    chk({8'h00, path_bits}, 16'(m_ien), "path");
  end

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #(20000 * 5);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    int op;
    errors    = 0;
    checked   = 0;
    resetn    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 16'h0000;
    ext_en    = 8'h00;
    ext_val   = 8'h00;
    void'($urandom(28831));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    sweep("reset_values");
    bus(1'b1, 1'b0, GPP_OFF_OUT_DATA, 16'hFF5A);
    bus(1'b1, 1'b0, GPP_OFF_OUT_SET, 16'h0081);
    bus(1'b1, 1'b0, GPP_OFF_OUT_CLEAR, 16'h0042);
    bus(1'b1, 1'b0, GPP_OFF_OUT_TOGGLE, 16'h00F0);
    bus(1'b0, 1'b1, GPP_OFF_OUT_DATA, 16'h0000);
    sweep("set_clear_toggle");
    repeat (600) begin
      op = $urandom_range(0, 2);
      bus(op == 1, op == 2, addrs[$urandom_range(0, 10)], 16'($urandom));
      if ($urandom_range(0, 5) == 0) begin
        ext_en  <= 8'($urandom);
        ext_val <= 8'($urandom);
      end
    end
    sweep("random_traffic");
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    sweep("midrun_reset");
    print_verdict();
  end
endmodule : gpp_port_tb
